//--- src/pwm_script_regs.sv
// Interrupt clear, pattern pointer and script word port of the PWM engine
`timescale 1ns/1ps
`default_nettype none
`include "pwm_script_params.svh"
module pwm_script_regs (
   input wire logic clock,
   input wire logic rst_n,
   input wire logic addr_valid,
   input wire logic [7:0] addr_byte,
   input wire logic wr_valid,
   input wire logic [7:0] wr_byte,
   input wire logic rd_req,
   input wire logic stop,
   input wire logic [2:0] cycle_done,
   input wire logic [2:0] pattern_done,
   input wire logic [2:0] cycle_mask,
   input wire logic [2:0] pattern_mask,
   input wire logic script_rd_en,
   input wire logic [6:0] script_rd_addr,
   output logic [15:0] script_rd_data,
   output logic rd_valid,
   output logic [7:0] rd_data,
   output logic [7:0] reg_addr,
   output logic [7:0] raw_timer_irq_status,
   output logic [7:0] masked_timer_irq_status,
   output logic timer_irq
);
   ////////////////////////////////////////////////////////////////////////////
   logic [7:0] reg_addr_reg;
   pwm_script_pkg::slot_t pointer_reg;
   pwm_script_pkg::pair_state_e pair_reg;
   logic [7:0] high_byte_reg;
   logic [5:0] raw_reg;
   logic [5:0] raw_next;
   logic [5:0] masked_reg;
   logic irq_reg;
   logic rd_valid_reg;
   logic [7:0] rd_data_reg;
   logic [5:0] set_vec;
   logic [5:0] clr_vec;
   logic [5:0] mask_vec;
   logic wr_clear;
   logic wr_pointer;
   logic wr_port;
   logic word_done;
   logic word_store;

   script_mem_if mem_bus ();

   script_mem #(
      .DEPTH(`SLOT_COUNT)
   ) u_store (
      .clock(clock),
      .rst_n(rst_n),
      .port(mem_bus.mem)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Address decode of the byte being written
   assign wr_clear = wr_valid && (reg_addr_reg == `ADDR_IRQ_CLEAR);
   assign wr_pointer = wr_valid && (reg_addr_reg == `ADDR_SLOT_POINTER);
   assign wr_port = wr_valid && (reg_addr_reg == `ADDR_SCRIPT_PORT);
   assign word_done = wr_port && (pair_reg == pwm_script_pkg::HAVE_HIGH);
   assign word_store = word_done && pwm_script_pkg::slot_valid(pointer_reg); // [R15] [R07]

   // Register address: loaded by the link, steps after each byte except on the script port
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         reg_addr_reg <= 8'h00;
      end else if (addr_valid) begin
         reg_addr_reg <= addr_byte;
      end else if ((wr_valid || rd_req) && (reg_addr_reg != `ADDR_SCRIPT_PORT)) begin // [R11]
         reg_addr_reg <= reg_addr_reg + 8'h01;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Byte pairing; a new address or STOP drops a half word
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         pair_reg <= pwm_script_pkg::WAIT_HIGH;
      end else if (addr_valid || stop) begin
         pair_reg <= pwm_script_pkg::WAIT_HIGH; // [R14] [R10]
      end else if (wr_port) begin
         case (pair_reg)
            pwm_script_pkg::WAIT_HIGH: pair_reg <= pwm_script_pkg::HAVE_HIGH; // [R14]
            pwm_script_pkg::HAVE_HIGH: pair_reg <= pwm_script_pkg::WAIT_HIGH;
            default: pair_reg <= pwm_script_pkg::WAIT_HIGH;
         endcase
      end
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         high_byte_reg <= 8'h00;
      end else if (wr_port && (pair_reg == pwm_script_pkg::WAIT_HIGH)) begin
         high_byte_reg <= wr_byte; // [R14]
      end
   end

   // Invalid pointer freezes so software sees where the load overran
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         pointer_reg <= `POINTER_RESET; // [R06]
      end else if (wr_pointer) begin
         pointer_reg <= wr_byte[6:0]; // [R06]
      end else if (word_store) begin
         pointer_reg <= pointer_reg + 7'h01; // [R08]
      end
   end

   assign mem_bus.we = word_store; // [R09]
   assign mem_bus.waddr = pointer_reg; // [R09] [R07]
   assign mem_bus.wdata = {high_byte_reg, wr_byte}; // [R12]
   assign mem_bus.re = script_rd_en;
   assign mem_bus.raddr = script_rd_addr;

   ////////////////////////////////////////////////////////////////////////////
   // Flags: a set in the clearing cycle wins
   assign set_vec = {pattern_done, cycle_done}; // [R04] [R05]
   assign clr_vec = wr_clear ? wr_byte[5:0] : 6'h00; // [R01] [R02] [R03]
   assign mask_vec = {pattern_mask, cycle_mask};
   assign raw_next = (raw_reg & ~clr_vec) | set_vec;

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         raw_reg <= 6'h00;
      end else begin
         raw_reg <= raw_next; // [R01] [R03] [R04] [R05]
      end
   end

   // Masking from raw_next keeps status and raw aligned in the same cycle
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         masked_reg <= 6'h00;
         irq_reg <= 1'b0;
      end else begin
         masked_reg <= raw_next & mask_vec; // [R13]
         irq_reg <= |(raw_next & mask_vec); // [R13]
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Read answers one cycle after the request; write-only registers read zero
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         rd_valid_reg <= 1'b0;
         rd_data_reg <= 8'h00;
      end else begin
         rd_valid_reg <= rd_req;
         if (rd_req) begin
            case (reg_addr_reg)
               `ADDR_SLOT_POINTER: rd_data_reg <= {1'b0, pointer_reg}; // [R06]
               `ADDR_MASKED_STATUS: rd_data_reg <= {2'b00, masked_reg}; // [R13]
               default: rd_data_reg <= 8'h00;
            endcase
         end
      end
   end

   assign script_rd_data = mem_bus.rdata;
   assign rd_valid = rd_valid_reg;
   assign rd_data = rd_data_reg;
   assign reg_addr = reg_addr_reg;
   assign raw_timer_irq_status = {2'b00, raw_reg};
   assign masked_timer_irq_status = {2'b00, masked_reg};
   assign timer_irq = irq_reg;

   ////////////////////////////////////////////////////////////////////////////
   // Reserved clear bits 7:6 are never decoded, so no flag can see them
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_n);

   AST_CLEAR_BITS: assert property ((wr_clear && !addr_valid && set_vec == 6'h00) // [R01]
      |=> raw_reg == ($past(raw_reg) & ~$past(wr_byte[5:0])))
      else $error("Clear write did not clear the selected flags");
   AST_CLEAR_MAP: assert property ((wr_clear && wr_byte[`CLR_PATTERN_LSB + 2] && pattern_done[2] == 1'b0) // [R02]
      |=> !raw_timer_irq_status[5])
      else $error("Bit 5 did not clear timer2 pattern-done");
   AST_ZERO_KEEPS: assert property ((wr_clear && wr_byte[5:0] == 6'h00) // [R03]
      |=> (raw_reg & $past(raw_reg)) == $past(raw_reg))
      else $error("Zero clear bits disturbed a flag");
   AST_CLEAR_PULSE: assert property ((wr_clear ##1 !wr_clear) // [R03]
      |=> ($past(raw_reg) & ~raw_reg) == 6'h00)
      else $error("Clear held on past its write");
   AST_SET_WINS: assert property ((set_vec != 6'h00) // [R04] [R05]
      |=> (raw_reg & $past(set_vec)) == $past(set_vec))
      else $error("Timer event lost");
   AST_POINTER_READ: assert property ((rd_req && !addr_valid && reg_addr_reg == `ADDR_SLOT_POINTER) // [R06]
      |=> rd_valid && rd_data == {1'b0, $past(pointer_reg)})
      else $error("Pointer read back wrong");
   AST_POINTER_WRITE: assert property (wr_pointer // [R06]
      |=> pointer_reg == $past(wr_byte[6:0]))
      else $error("Pointer write not taken");
   AST_POINTER_STEP: assert property ((word_done && !wr_pointer && pwm_script_pkg::slot_valid(pointer_reg)) // [R08]
      |=> pointer_reg == $past(pointer_reg) + 7'h01)
      else $error("Pointer did not step after a word");
   AST_INVALID_DROP: assert property ((word_done && !pwm_script_pkg::slot_valid(pointer_reg)) // [R15]
      |-> !mem_bus.we ##1 pointer_reg == $past(pointer_reg))
      else $error("Word stored through invalid pointer");
   AST_WORD_LAYOUT: assert property (mem_bus.we // [R12]
      |-> mem_bus.wdata[15:8] == high_byte_reg && mem_bus.waddr == pointer_reg)
      else $error("Script word assembled wrongly");
   AST_PORT_STAYS: assert property ((wr_port && !addr_valid) |=> reg_addr_reg == `ADDR_SCRIPT_PORT) // [R11]
      else $error("Address moved off the script port");
   AST_ADDR_STEP: assert property ((wr_valid && !addr_valid && reg_addr_reg != `ADDR_SCRIPT_PORT) // [R11]
      |=> reg_addr_reg == $past(reg_addr_reg) + 8'h01)
      else $error("Address did not step after a byte");
   AST_LONE_BYTE: assert property ((stop && pair_reg == pwm_script_pkg::HAVE_HIGH && !wr_valid) // [R14]
      |=> pair_reg == pwm_script_pkg::WAIT_HIGH && !mem_bus.we)
      else $error("Lone byte not dropped");
   AST_MASKED: assert property (masked_reg == (raw_reg & $past(mask_vec)) && timer_irq == |masked_reg) // [R13]
      else $error("Masked status disagrees with raw and mask");

   COV_WORD_STORED: cover property ((wr_port && pair_reg == pwm_script_pkg::WAIT_HIGH) ##2 mem_bus.we);
   COV_CLEAR_AND_SET: cover property (wr_clear && (clr_vec & set_vec) != 6'h00);
   COV_INVALID_WORD: cover property (word_done && !pwm_script_pkg::slot_valid(pointer_reg));
   COV_LONE_DROP: cover property (stop && pair_reg == pwm_script_pkg::HAVE_HIGH);
   COV_IRQ: cover property (timer_irq);
endmodule // pwm_script_regs
`default_nettype wire

//--- src/pwm_script_params.svh
// Constants for the PWM interrupt clear, pattern pointer and script port
// Operation
// R01: Writing the clear register clears each pending flag whose written bit is one.
// R02: Bits 5:3 clear pattern-done t2..t0, bits 2:0 cycle-done t2..t0; 7:6 reserved.
// R03: A zero bit leaves its flag alone; clearing is a single pulse.
// R04: A timer's cycle-done flag rises when its active command's PWM cycle ends.
// R05: A timer's pattern-done flag rises when its script task finishes.
// R06: Pattern pointer is read/write, 7 bits in 6:0, bit 7 reserved, reset zero.
// R07: Pointer 0-31 timer0, 32-63 timer1, 64-95 timer2 slots; 96 up invalid.
// R08: Pointer counts whole words and increments by one after each word write; the code holds it when the pointer is 96 or above.
// R09: Each complete word write overwrites the slot the pointer selects.
// R10: Host sends a script word as two consecutive bytes in one write transaction.
// R11: Register address does not auto-increment on the script data port.
// R12: Script word has the high byte in 15:8 and the low byte in 7:0.
// R13: Masked status and interrupt output equal raw flags ANDed with mask bits.
// R14: First byte is the high byte, second the low; a lone byte is dropped.
// R15: A word write with pointer at 96 or above is dropped, no slot changes.
`ifndef PWM_SCRIPT_PARAMS_SVH
`define PWM_SCRIPT_PARAMS_SVH

`define ADDR_MASKED_STATUS 8'h7b
`define ADDR_IRQ_CLEAR 8'h7c
`define ADDR_SLOT_POINTER 8'h7d
`define ADDR_SCRIPT_PORT 8'h7e

`define CLR_CYCLE_LSB 0
`define CLR_PATTERN_LSB 3
`define FLAG_BITS 6

`define POINTER_RESET 7'h00
`define SLOTS_PER_TIMER 32
`define SLOT_COUNT 96

`endif

//--- src/pwm_script_pkg.sv
// Types shared by the PWM script register logic
`default_nettype none
`include "pwm_script_params.svh"
package pwm_script_pkg;
   // Gray order along idle -> high byte held
   typedef enum logic [0:0] {
      WAIT_HIGH = 1'b0,
      HAVE_HIGH = 1'b1
   } pair_state_e;

   typedef logic [6:0] slot_t;
   typedef logic [15:0] script_word_t;

   // Slot 96 and above has no storage behind it
   function automatic logic slot_valid(input slot_t ptr);
      slot_valid = ({25'h0000000, ptr} < `SLOT_COUNT);
   endfunction
endpackage
`default_nettype wire

//--- src/script_mem_if.sv
// Write and read port between register logic and the script store
`timescale 1ns/1ps
`default_nettype none
interface script_mem_if;
   logic we;
   pwm_script_pkg::slot_t waddr;
   pwm_script_pkg::script_word_t wdata;
   logic re;
   pwm_script_pkg::slot_t raddr;
   pwm_script_pkg::script_word_t rdata;

   modport user (output we, output waddr, output wdata, output re, output raddr, input rdata);
   modport mem (input we, input waddr, input wdata, input re, input raddr, output rdata);
endinterface
`default_nettype wire

//--- src/script_mem.sv
// Script slot store, registered read
`timescale 1ns/1ps
`default_nettype none
`include "pwm_script_params.svh"
module script_mem #(
   parameter int DEPTH = `SLOT_COUNT
) (
   input wire logic clock,
   input wire logic rst_n,
   script_mem_if.mem port
);
   pwm_script_pkg::script_word_t mem_reg [DEPTH];
   pwm_script_pkg::script_word_t rdata_reg;

   // No reset on the array: scripts are always loaded before use
   always_ff @(posedge clock) begin
      if (port.we) begin
         mem_reg[port.waddr] <= port.wdata;
      end
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         rdata_reg <= 16'h0000;
      end else if (port.re && ({25'h0000000, port.raddr} < DEPTH)) begin
         rdata_reg <= mem_reg[port.raddr];
      end
   end

   assign port.rdata = rdata_reg;

   AST_MEM_IN_RANGE: assert property (@(posedge clock) disable iff (!rst_n) // [R15]
      port.we |-> ({25'h0000000, port.waddr} < DEPTH))
      else $error("Script store written outside its slots");
endmodule // script_mem
`default_nettype wire

//--- sim/host_link_model.sv
// Host model driving the byte-level register link
`timescale 1ns/1ps
`default_nettype none
module host_link_model (
   input wire logic clock,
   input wire logic rd_valid,
   input wire logic [7:0] rd_data,
   output logic addr_valid,
   output logic [7:0] addr_byte,
   output logic wr_valid,
   output logic [7:0] wr_byte,
   output logic rd_req,
   output logic stop
);
   initial begin
      {stop, rd_req, wr_valid, addr_valid} = 4'h0;
      addr_byte = 8'h00;
      wr_byte = 8'h00;
   end
   // Kind 0 address, 1 data, 2 read, 3 stop
   task automatic strobe(input int k, input logic [7:0] b);
      @(posedge clock);
      #1;
      addr_byte = b;
      wr_byte = b;
      {stop, rd_req, wr_valid, addr_valid} = 4'h1 << k;
      @(posedge clock);
      #1;
      {stop, rd_req, wr_valid, addr_valid} = 4'h0;
      // Released lines flip so a stale byte never looks valid
      addr_byte = ~b;
      wr_byte = ~b;
   endtask
   // High byte first, both within one transfer
   task automatic word(input logic [15:0] w);
      strobe(1, w[15:8]);
      strobe(1, w[7:0]);
   endtask
   task automatic read(output logic [7:0] d, output logic ok);
      strobe(2, 8'h00);
      ok = 1'b0;
      d = 8'h00;
      for (int i = 0; i < 4 && !ok; i++) begin
         if (rd_valid === 1'b1) begin
            ok = 1'b1;
            d = rd_data;
         end else begin
            @(posedge clock);
            #1;
         end
      end
   endtask
endmodule // host_link_model
`default_nettype wire

//--- sim/test_pwm_script_regs.sv
// Self-checking bench for the PWM script register logic
`timescale 1ns/1ps
`default_nettype none
`include "pwm_script_params.svh"
module test_pwm_script_regs;
   logic clock, rst_n, sre, av, wv, rq, sp, rv, irq;
   logic [2:0] cd, pd, cm, pm;
   logic [6:0] sra;
   logic [15:0] srd;
   logic [7:0] ab, wb, rd, ra, raw, msk;
   int mismatches = 0;
   int n_checks = 0;
   pwm_script_regs pwm_script_regs_i (.clock(clock), .rst_n(rst_n), .addr_valid(av), .addr_byte(ab),
      .wr_valid(wv), .wr_byte(wb), .rd_req(rq), .stop(sp), .cycle_done(cd), .pattern_done(pd),
      .cycle_mask(cm), .pattern_mask(pm), .script_rd_en(sre), .script_rd_addr(sra),
      .script_rd_data(srd), .rd_valid(rv), .rd_data(rd), .reg_addr(ra), .raw_timer_irq_status(raw),
      .masked_timer_irq_status(msk), .timer_irq(irq));
   host_link_model host_link_model_i (.clock(clock), .rd_valid(rv), .rd_data(rd), .addr_valid(av),
      .addr_byte(ab), .wr_valid(wv), .wr_byte(wb), .rd_req(rq), .stop(sp));
   task automatic print_verdict;
      if (mismatches == 0 && n_checks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      n_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("[ERR] %0t got %h want %h", $time, got, exp);
      end
   endtask
   task automatic sb(input int k, input logic [7:0] b);
      host_link_model_i.strobe(k, b);
   endtask
   task automatic rd_reg(input logic [7:0] a, input logic [7:0] exp);
      logic [7:0] d;
      logic ok;
      sb(0, a);
      host_link_model_i.read(d, ok);
      chk({7'h00, ok, d}, {8'h01, exp});
   endtask
   task automatic rd_slot(input logic [6:0] a, input logic [15:0] exp);
      @(posedge clock);
      #1;
      sra = a;
      sre = 1'b1;
      @(posedge clock);
      #1;
      sre = 1'b0;
      chk(srd, exp);
   endtask
   task automatic set_ptr(input logic [7:0] p);
      sb(0, `ADDR_SLOT_POINTER);
      sb(1, p);
   endtask
   task automatic pulse(input logic [2:0] c, input logic [2:0] p);
      @(posedge clock);
      #1;
      cd = c;
      pd = p;
      @(posedge clock);
      #1;
      cd = 3'h0;
      pd = 3'h0;
   endtask
   ////////////////////////////////////////////////////////////////////////////
   task automatic t_pointer;
      rd_reg(`ADDR_SLOT_POINTER, 8'h00);
      set_ptr(8'hdf);
      rd_reg(`ADDR_SLOT_POINTER, 8'h5f);
   endtask
   task automatic t_words;
      set_ptr(8'h1f);
      sb(0, `ADDR_SCRIPT_PORT);
      host_link_model_i.word(16'ha1b2);
      chk({8'h00, ra}, 16'h007e);
      host_link_model_i.word(16'hc3d4);
      rd_reg(`ADDR_SLOT_POINTER, 8'h21);
      rd_slot(7'h1f, 16'ha1b2);
      rd_slot(7'h20, 16'hc3d4);
   endtask
   task automatic t_lone;
      set_ptr(8'h05);
      sb(0, `ADDR_SCRIPT_PORT);
      sb(1, 8'h99);
      sb(3, 8'h00);
      sb(0, `ADDR_SCRIPT_PORT);
      host_link_model_i.word(16'h1234);
      rd_slot(7'h05, 16'h1234);
      rd_reg(`ADDR_SLOT_POINTER, 8'h06);
   endtask
   task automatic t_invalid;
      set_ptr(8'h5f);
      sb(0, `ADDR_SCRIPT_PORT);
      host_link_model_i.word(16'h5a5a);
      host_link_model_i.word(16'h0f0f);
      rd_reg(`ADDR_SLOT_POINTER, 8'h60);
      rd_slot(7'h5f, 16'h5a5a);
   endtask
   task automatic t_flags;
      chk({8'h00, raw}, 16'h0000);
      cm = 3'h5;
      pm = 3'h2;
      pulse(3'h7, 3'h7);
      chk({8'h00, raw}, 16'h003f);
      @(posedge clock);
      #1;
      chk({7'h00, irq, msk}, 16'h0115);
      rd_reg(`ADDR_MASKED_STATUS, 8'h15);
      sb(0, `ADDR_IRQ_CLEAR);
      sb(1, 8'hc0);
      chk({8'h00, raw}, 16'h003f);
      for (int i = 0; i < 6; i++) begin
         sb(0, `ADDR_IRQ_CLEAR);
         sb(1, 8'h01 << i);
         chk({8'h00, raw}, 16'h003f & ~((16'h0002 << i) - 16'h0001));
      end
      @(posedge clock);
      #1;
      chk({15'h0000, irq}, 16'h0000);
      // A held clear cannot block this new event, since a set wins; it would only wipe the flag on a later cycle
      pulse(3'h2, 3'h4);
      chk({8'h00, raw}, 16'h0022);
      // Event and clear in one cycle: the event must survive
      sb(0, `ADDR_IRQ_CLEAR);
      fork
         sb(1, 8'h22);
         pulse(3'h2, 3'h0);
      join
      chk({8'h00, raw}, 16'h0002);
   endtask
   task automatic t_reset;
      set_ptr(8'h10);
      pulse(3'h1, 3'h0);
      @(posedge clock);
      #1;
      rst_n = 1'b0;
      @(posedge clock);
      #1;
      rst_n = 1'b1;
      chk({7'h00, irq, raw}, 16'h0000);
      chk({8'h00, msk}, 16'h0000);
      rd_reg(`ADDR_SLOT_POINTER, 8'h00);
   endtask
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      clock = 1'b0;
      forever #4 clock = ~clock;
   end
   initial begin
      rst_n = 1'b0;
      {cd, pd, cm, pm} = 12'h000;
      sre = 1'b0;
      sra = 7'h00;
      repeat (2) @(posedge clock);
      #1;
      rst_n = 1'b1;
      t_pointer();
      t_words();
      t_lone();
      t_invalid();
      t_flags();
      t_reset();
      print_verdict();
   end
   initial begin
      #100000;
      mismatches++;
      print_verdict();
   end
endmodule // test_pwm_script_regs
`default_nettype wire
